// >>> design/fsbrw_map.svh
// Constants for the synchronous burst read wait block
`ifndef FSBRW_MAP_SVH
`define FSBRW_MAP_SVH

// ****************************************
// Configuration encodings
// ****************************************
`define FSBRW_BL_4          3'h1
`define FSBRW_BL_8          3'h2
`define FSBRW_BL_16         3'h3
`define FSBRW_BL_CONT       3'h7
`define FSBRW_LEN_4         5'h04
`define FSBRW_LEN_8         5'h08
`define FSBRW_LEN_16        5'h10
`define FSBRW_LEN_CONT      5'h00
`define FSBRW_ORDER_LINEAR  1'h0

// ****************************************
// Timing counts and reset values
// ****************************************
`define FSBRW_LAT_MIN       4'h3
`define FSBRW_LAT_END_OF_WORDLINE_MIN  4'h5
`define FSBRW_ADDR_RESET    16'h0000
`define FSBRW_DATA_RESET    16'h0000

`endif

// >>> design/fsbrw_pkg.sv
// Types and shared decoding for the synchronous burst read wait block
`include "fsbrw_map.svh"

package fsbrw_pkg;

    typedef enum logic [1:0] {
        FSBRW_IDLE  = 2'b00,
        FSBRW_LAT   = 2'b01,
        FSBRW_BURST = 2'b10,
        FSBRW_DONE  = 2'b11
    } fsbrw_phase_t;

    typedef struct packed {
        fsbrw_phase_t phase;
        logic [3:0]   gap;
        logic [4:0]   words;
        logic         end_of_wordline_done;
        logic         unaligned;
        logic [1:0]   start_lo;
        logic         valid;
        logic         asserted;
        logic         asserted_late;
        logic [15:0]  addr;
        logic [15:0]  dq;
        logic [15:0]  dq_late;
    } fsbrw_state_t;

    // Burst length code to word count, zero for continuous
    function automatic logic [4:0] fsbrw_len_words(input logic [2:0] code);
        logic [4:0] len;
        len = `FSBRW_LEN_CONT;
        if (code == `FSBRW_BL_4)
            len = `FSBRW_LEN_4;
        else if (code == `FSBRW_BL_8)
            len = `FSBRW_LEN_8;
        else if (code == `FSBRW_BL_16)
            len = `FSBRW_LEN_16;
        return len;
    endfunction : fsbrw_len_words

endpackage : fsbrw_pkg

// >>> design/fsbrw_addr_step.sv
// Next word address of a linear burst, with or without wrap
`timescale 1ns/1ns
`include "fsbrw_map.svh"

module fsbrw_addr_step
    import fsbrw_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic [2:0]  burst_length,
    input  wire logic        burst_wrap,
    output logic      [15:0] next_addr
);

    logic [4:0]  len;
    logic [15:0] mask;
    logic [15:0] inc;

    always_comb
    begin
        len  = fsbrw_len_words(burst_length);
        inc  = addr + 16'h0001;
        mask = {11'h000, len - 5'h01};
        if (len != `FSBRW_LEN_CONT && !burst_wrap)
            next_addr = (addr & ~mask) | (inc & mask); // RL14
        else
            next_addr = inc; // RL15 RL16
    end

endmodule : fsbrw_addr_step

// >>> design/fsbrw_burst_read.sv
// Synchronous burst read output, latency and wait handshake of a NOR flash
//
// Rules of the document for this block
// RL1 - First data only after programmed latency cycles
// RL2 - Host picks latency covering access time
// RL3 - Unaligned start may stall at wordline end
// RL4 - Wordline stall below latency count, once
// RL5 - Polarity bit sets asserted wait level
// RL6 - Wait changes only during active cycles
// RL7 - Wait marks valid data in synchronous reads
// RL8 - Nonarray wordline wait trusted first word only
// RL9 - Async reads and writes hold wait deasserted
// RL10 - Wait released unless chip and output enabled
// RL11 - Delay bit moves wait release one earlier
// RL12 - Burst order always linear
// RL13 - Length codes 4, 8, 16, continuous
// RL14 - Wrapping burst stays in aligned block
// RL15 - Non-wrapping burst crosses block boundary
// RL16 - Continuous burst always linear
// RL17 - Read mode bit selects sync or async
// RL18 - Latency codes below three are reserved
// RL19 - Clock edge bit selects output edge
// RL20 - Host samples data only without wait
`timescale 1ns/1ns
`include "fsbrw_map.svh"

module fsbrw_burst_read
    import fsbrw_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        address_valid_n,
    input  wire logic        chip_en_n,
    input  wire logic        out_en_n,
    input  wire logic        write_en_n,
    input  wire logic [15:0] start_addr,
    input  wire logic        nonarray_read,
    input  wire logic        read_mode,
    input  wire logic [3:0]  latency_count,
    input  wire logic        wait_polarity,
    input  wire logic        wait_delay,
    input  wire logic        clock_edge,
    input  wire logic        burst_wrap,
    input  wire logic [2:0]  burst_length,
    input  wire logic [15:0] mem_data,
    output logic      [15:0] mem_addr,
    output logic      [15:0] dq_out,
    output logic             dq_oe_n,
    output logic             wait_out,
    output logic             wait_oe_n,
    output logic             burst_order,
    output logic             data_valid
);

    fsbrw_state_t st;
    fsbrw_state_t next_st;
    logic [15:0]  step_addr;
    logic [3:0]   lat_eff;
    logic [4:0]   len;
    logic         sync;
    logic         active;
    logic         nn_valid;
    logic         asserted_sel;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] end_of_wordline_waits(input logic [1:0] lo, input logic [3:0] lat);
        logic [3:0] w;
        w = {2'h0, lo};
        if (lo == 2'h3)
            w = lat - 4'h1;
        return w;
    endfunction : end_of_wordline_waits

    function automatic logic end_of_wordline_due(input fsbrw_state_t s, input logic [3:0] lat,
                                      input logic linear, input logic nonarr);
        return s.phase == FSBRW_BURST && s.addr[3:0] == 4'h0 && !s.end_of_wordline_done
            && s.unaligned && linear && !nonarr && lat >= `FSBRW_LAT_END_OF_WORDLINE_MIN
            && end_of_wordline_waits(s.start_lo, lat) != 4'h0;
    endfunction : end_of_wordline_due

    fsbrw_addr_step u_step (
        .addr         (st.addr),
        .burst_length (burst_length),
        .burst_wrap   (burst_wrap),
        .next_addr    (step_addr)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_st  = st;
        lat_eff  = (latency_count < `FSBRW_LAT_MIN) ? `FSBRW_LAT_MIN : latency_count; // RL18
        len      = fsbrw_len_words(burst_length); // RL13
        sync     = !read_mode; // RL17
        active   = !chip_en_n && !out_en_n;
        nn_valid = 1'b0;
        if (chip_en_n)
        begin
            next_st.phase = FSBRW_IDLE;
            next_st.valid = 1'b0;
        end
        else if (!address_valid_n)
        begin
            next_st.addr      = start_addr;
            next_st.unaligned = start_addr[3:0] != 4'h0; // RL3
            next_st.start_lo  = start_addr[1:0];
            next_st.end_of_wordline_done = 1'b0;
            next_st.words     = 5'h00;
            next_st.valid     = 1'b0;
            next_st.gap       = lat_eff - 4'h1; // RL1
            next_st.phase     = sync ? FSBRW_LAT : FSBRW_IDLE;
        end
        else
        begin
            unique case (st.phase)
                FSBRW_IDLE:
                begin
                    next_st.valid = 1'b0;
                    if (!sync)
                        next_st.dq = mem_data;
                end
                FSBRW_LAT, FSBRW_BURST:
                begin
                    if (st.gap != 4'h0)
                    begin
                        next_st.gap   = st.gap - 4'h1;
                        next_st.valid = 1'b0;
                    end
                    else if (end_of_wordline_due(st, lat_eff, burst_wrap || len == `FSBRW_LEN_CONT,
                                      nonarray_read))
                    begin
                        next_st.gap       = end_of_wordline_waits(st.start_lo, lat_eff) - 4'h1; // RL4
                        next_st.end_of_wordline_done = 1'b1;
                        next_st.valid     = 1'b0;
                    end
                    else
                    begin
                        next_st.dq    = mem_data;
                        next_st.valid = 1'b1;
                        next_st.words = st.words + 5'h01;
                        next_st.addr  = nonarray_read ? st.addr : step_addr;
                        next_st.phase = (len != `FSBRW_LEN_CONT && st.words + 5'h01 == len)
                                        ? FSBRW_DONE : FSBRW_BURST;
                    end
                end
                FSBRW_DONE:
                begin
                    next_st.valid = 1'b1;
                end
            endcase
        end
        // Validity one edge beyond the next, for early wait release
        if (next_st.phase == FSBRW_DONE)
            nn_valid = 1'b1;
        else if (next_st.phase != FSBRW_IDLE && next_st.gap == 4'h0)
            nn_valid = !end_of_wordline_due(next_st, lat_eff, burst_wrap || len == `FSBRW_LEN_CONT,
                                 nonarray_read);
        if (active) // RL6
        begin
            if (!sync || !write_en_n || next_st.phase == FSBRW_IDLE)
                next_st.asserted = 1'b0; // RL9
            else if (wait_delay)
                next_st.asserted = !nn_valid; // RL11
            else
                next_st.asserted = !next_st.valid; // RL7 RL8
        end
        next_st.dq_late       = st.dq;
        next_st.asserted_late = st.asserted;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st <= '{phase: FSBRW_IDLE, gap: 4'h0, words: 5'h00, end_of_wordline_done: 1'b0,
                    unaligned: 1'b0, start_lo: 2'h0, valid: 1'b0, asserted: 1'b0,
                    asserted_late: 1'b0, addr: `FSBRW_ADDR_RESET,
                    dq: `FSBRW_DATA_RESET, dq_late: `FSBRW_DATA_RESET};
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Falling edge output approximated by one extra stage
    assign asserted_sel = clock_edge ? st.asserted : st.asserted_late; // RL19
    assign dq_out       = clock_edge ? st.dq : st.dq_late;
    assign wait_out     = asserted_sel ? wait_polarity : !wait_polarity; // RL5
    assign wait_oe_n    = !active; // RL10
    assign dq_oe_n      = !active;
    assign mem_addr     = st.addr;
    assign burst_order  = `FSBRW_ORDER_LINEAR; // RL12
    assign data_valid   = st.valid;

    // ****************************************
    // Checks
    // ****************************************
    logic [4:0] since_adv;
    logic [15:0] prev_addr;
    always_ff @(posedge ref_clk)
    begin
        if (reset || (!address_valid_n && !chip_en_n))
            since_adv <= 5'h00;
        else if (since_adv != 5'h1F)
            since_adv <= since_adv + 5'h01;
        prev_addr <= st.addr;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_load;
        st.valid && $past(st.phase) == FSBRW_LAT;
    endsequence
    sequence s_stall;
        st.phase == FSBRW_BURST && !st.valid && $past(st.valid);
    endsequence

    a_first_latency: assert property (s_load |-> since_adv == {1'b0, lat_eff}) // RL1
        else $error("first word not at latency count");
    a_end_of_wordline_boundary: assert property (s_stall |-> st.end_of_wordline_done && st.addr[3:0] == 4'h0) // RL3
        else $error("stall away from wordline boundary");
    a_end_of_wordline_bound: assert property (s_stall |-> st.gap < lat_eff - 4'h1) // RL4
        else $error("wordline stall too long");
    a_wait_level: assert property (clock_edge && !wait_oe_n && st.phase == FSBRW_LAT // RL5
                                   && st.gap != 4'h0 && $past(active) && !$past(read_mode)
                                   && $past(write_en_n) |-> wait_out == wait_polarity)
        else $error("wait level not per polarity");
    a_wait_hold: assert property (!active |=> $stable(st.asserted)) // RL6
        else $error("wait moved outside active cycle");
    a_wait_valid: assert property (active && sync && !wait_delay && write_en_n
                                   && st.phase != FSBRW_IDLE ##1 active
                                   |-> st.asserted == !st.valid) // RL7
        else $error("wait not tracking valid data");
    a_wait_early: assert property (active && sync && wait_delay && st.phase == FSBRW_LAT
                                   && st.gap == 4'h1 && address_valid_n && !chip_en_n
                                   |=> !st.asserted ##1 st.valid) // RL11
        else $error("early wait release misplaced");
    a_async_quiet: assert property (active && (read_mode || !write_en_n) |=> !st.asserted) // RL9
        else $error("wait asserted in async or write");
    a_wait_hiz: assert property (chip_en_n || out_en_n |-> wait_oe_n) // RL10
        else $error("wait driven while bus idle");
    a_wrap_step: assert property (st.valid && $past(st.valid) && $past(st.phase) == FSBRW_BURST
                                  && len != `FSBRW_LEN_CONT && !burst_wrap && !nonarray_read
                                  |-> st.addr[15:4] == prev_addr[15:4]) // RL14
        else $error("wrapping burst left block");
    a_linear_step: assert property (st.valid && $past(st.valid) && $past(st.phase) == FSBRW_BURST
                                    && (burst_wrap || len == `FSBRW_LEN_CONT) && !nonarray_read
                                    |-> st.addr == prev_addr + 16'h0001) // RL15 RL16
        else $error("linear burst skipped a word");

endmodule : fsbrw_burst_read

// >>> testbench/fsbrw_array_model.sv
// Flash array stand-in answering the block's array address
`timescale 1ns/1ns

module fsbrw_array_model
    import fsbrw_pkg::*;
(
    input  wire logic [15:0] mem_addr,
    output logic      [15:0] mem_data
);
    // Byte swap plus mask so that neighbouring words all differ
    assign mem_data = {mem_addr[7:0], mem_addr[15:8]} ^ 16'hC3C3;
endmodule : fsbrw_array_model

// >>> testbench/fsbrw_burst_read_bench.sv
// Self-checking bench for the synchronous burst read block
`timescale 1ns/1ns

module fsbrw_burst_read_bench
    import fsbrw_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        reset, address_valid_n, chip_en_n, out_en_n, write_en_n;
    logic [15:0] start_addr, mem_data, mem_addr, dq_out;
    logic        nonarray_read, read_mode, wait_polarity, wait_delay, clock_edge;
    logic [3:0]  latency_count;
    logic        burst_wrap, dq_oe_n, wait_out, wait_oe_n, burst_order, data_valid;
    logic [2:0]  burst_length;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #25 ref_clk = ~ref_clk;

    fsbrw_burst_read u_fsbrw_burst_read (
        .ref_clk(ref_clk), .reset(reset), .address_valid_n(address_valid_n),
        .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .start_addr(start_addr), .nonarray_read(nonarray_read), .read_mode(read_mode),
        .latency_count(latency_count), .wait_polarity(wait_polarity),
        .wait_delay(wait_delay), .clock_edge(clock_edge), .burst_wrap(burst_wrap),
        .burst_length(burst_length), .mem_data(mem_data), .mem_addr(mem_addr),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wait_out(wait_out), .wait_oe_n(wait_oe_n),
        .burst_order(burst_order), .data_valid(data_valid)
    );

    fsbrw_array_model u_fsbrw_array_model (.mem_addr(mem_addr), .mem_data(mem_data));

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic tally_and_finish();
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_cnt(input string what, input int exp, input int got);
        n_tests++;
        if (got != exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt

    function automatic logic [15:0] exp_word(input int a);
        logic [15:0] w;
        w = a[15:0];
        return {w[7:0], w[15:8]} ^ 16'hC3C3;
    endfunction : exp_word

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic burst(input logic [15:0] sa, input logic [2:0] bl, input logic wr,
                         input logic [3:0] lat, input logic nonarr, input int n, input int gap);
        int k, i, first, gaps, len, ai, sh, le;
        logic [15:0] pend_w;
        logic        pend, ws;
        k = 0;
        i = 0;
        first = 0;
        gaps = 0;
        pend = 1'b0;
        pend_w = 16'h0000;
        ws = 1'b0;
        sh = clock_edge ? 0 : 1;
        le = (lat < 4'h3) ? 3 : lat;
        len = (bl == 3'h1) ? 4 : (bl == 3'h2) ? 8 : (bl == 3'h3) ? 16 : 0;
        burst_length = bl;
        burst_wrap = wr;
        latency_count = lat;
        nonarray_read = nonarr;
        start_addr = sa;
        chip_en_n = 1'b0;
        out_en_n = 1'b0;
        address_valid_n = 1'b0;
        @(negedge ref_clk);
        address_valid_n = 1'b1;
        while (i < n && k < 80)
        begin
            @(negedge ref_clk);
            k++;
            if (pend)
                check_word("late burst word", pend_w, dq_out);
            pend = 1'b0;
            if (k == 1)
            begin
                check_bit("wait first cycle", wait_polarity, wait_out);
                check_bit("wait oe active", 1'b0, wait_oe_n);
                check_bit("dq oe active", 1'b0, dq_oe_n);
                check_word("array address", sa, mem_addr);
            end
            if (k == le - 1 + sh)
                check_bit("wait before data", wait_polarity ^ wait_delay, wait_out);
            if (k == le + sh && wait_delay == 1'b0)
                check_bit("wait at data", ~wait_polarity, wait_out);
            if (data_valid === 1'b1)
            begin
                if (i == 0)
                    first = k;
                ai = sa + (nonarr ? 0 : i);
                if (len != 0 && !wr)
                    ai = (sa & ~(len - 1)) | (ai & (len - 1));
                pend_w = exp_word(ai);
                if (clock_edge)
                    check_word("burst word", pend_w, dq_out);
                else
                    pend = 1'b1;
                if (clock_edge && !wait_delay)
                    check_bit("wait with data", ~wait_polarity, wait_out);
                i++;
            end
            else if (i > 0)
            begin
                gaps++;
                ws = (!wait_delay || gaps < gap) ? wait_polarity : ~wait_polarity;
                if (clock_edge)
                    check_bit("wait in stall", ws, wait_out);
            end
        end
        check_cnt("burst words", n, i);
        check_cnt("first word cycle", le, first);
        check_cnt("stall cycles", gap, gaps);
        chip_en_n = 1'b1;
        out_en_n = 1'b1;
        @(negedge ref_clk);
        if (pend)
            check_word("late burst word", pend_w, dq_out);
        check_bit("idle valid", 1'b0, data_valid);
        check_bit("idle wait oe", 1'b1, wait_oe_n);
        check_bit("idle dq oe", 1'b1, dq_oe_n);
    endtask : burst

    task automatic quiet_cycle();
        chip_en_n = 1'b0;
        out_en_n = 1'b0;
        address_valid_n = 1'b0;
        start_addr = 16'h0003;
        @(negedge ref_clk);
        address_valid_n = 1'b1;
        repeat (6)
        begin
            @(negedge ref_clk);
            check_bit("wait held", ~wait_polarity, wait_out);
        end
        chip_en_n = 1'b1;
        out_en_n = 1'b1;
        @(negedge ref_clk);
    endtask : quiet_cycle

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        reset = 1'b1;
        address_valid_n = 1'b1;
        chip_en_n = 1'b1;
        out_en_n = 1'b1;
        write_en_n = 1'b1;
        start_addr = 16'h0000;
        nonarray_read = 1'b0;
        read_mode = 1'b0;
        latency_count = 4'h5;
        wait_polarity = 1'b1;
        wait_delay = 1'b0;
        clock_edge = 1'b1;
        burst_wrap = 1'b1;
        burst_length = 3'h7;
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        @(negedge ref_clk);
        check_bit("wait after reset", 1'b0, wait_out);
        check_bit("wait oe idle", 1'b1, wait_oe_n);
        check_bit("burst order", 1'b0, burst_order);
        for (int p = 0; p < 4; p++)
        begin
            wait_polarity = p[0];
            wait_delay = p[1];
            burst(16'h0001, 3'h1, 1'b0, 4'h5, 1'b0, 4, 0);
        end
        burst(16'h0001, 3'h1, 1'b1, 4'h3, 1'b0, 4, 0);
        burst(16'h0001, 3'h1, 1'b1, 4'h1, 1'b0, 4, 0);
        burst(16'h0005, 3'h2, 1'b0, 4'h7, 1'b0, 8, 0);
        burst(16'h0005, 3'h3, 1'b0, 4'h5, 1'b0, 16, 0);
        burst(16'h0005, 3'h3, 1'b1, 4'h5, 1'b0, 16, 1);
        burst(16'h000C, 3'h2, 1'b1, 4'h5, 1'b0, 8, 0);
        burst(16'h000D, 3'h7, 1'b0, 4'h5, 1'b0, 6, 1);
        burst(16'h000E, 3'h7, 1'b1, 4'h6, 1'b0, 6, 2);
        wait_delay = 1'b0;
        burst(16'h000F, 3'h7, 1'b1, 4'h5, 1'b0, 6, 4);
        wait_delay = 1'b1;
        burst(16'h000F, 3'h7, 1'b1, 4'h4, 1'b0, 6, 0);
        clock_edge = 1'b0;
        burst(16'h000E, 3'h7, 1'b1, 4'h5, 1'b0, 4, 2);
        clock_edge = 1'b1;
        burst(16'h000D, 3'h7, 1'b1, 4'hF, 1'b1, 6, 0);
        for (int p = 0; p < 2; p++)
        begin
            wait_polarity = p[0];
            read_mode = 1'b1;
            quiet_cycle();
            read_mode = 1'b0;
            write_en_n = 1'b0;
            quiet_cycle();
            write_en_n = 1'b1;
        end
        tally_and_finish();
    end
endmodule : fsbrw_burst_read_bench
